// ==== inc/adw_pkg.sv ====
package adw_pkg;

  // Frame and command geometry
  localparam int           SEG_N      = 256;
  localparam int           LANE_N     = 32;
  localparam int           BYTE_W     = 8;
  localparam int           IDX_W      = 5;
  localparam int           LANE_W     = 6;
  localparam logic [6:0]   CMD_AUTO_WRITE_ONE = 7'h03;
  localparam logic [5:0]   LANE_LIMIT = 6'h20;
  localparam logic [5:0]   LANE_STEP  = 6'h01;

  // Waveform slots
  localparam logic [2:0]   WAVE_SLOT_ONE  = 3'h1;
  localparam logic [2:0]   WAVE_SLOT_NONE = 3'h0;

  // Register byte addresses on the bus
  localparam logic [7:0]   ADDR_CTRL       = 8'h00;
  localparam logic [7:0]   ADDR_RANGE      = 8'h04;
  localparam logic [7:0]   ADDR_STATUS     = 8'h08;
  localparam logic [7:0]   ADDR_IMAGE_BASE = 8'h20;
  localparam logic [7:0]   ADDR_IMAGE_LAST = 8'h3C;

  // Field positions
  localparam int           CTRL_FLASH_DIS_BIT = 0;
  localparam int           CTRL_AUTO_TEMP_BIT = 1;
  localparam int           CTRL_POL_LSB       = 2;
  localparam int           RANGE_FIRST_LSB    = 0;
  localparam int           RANGE_LAST_LSB     = 8;
  localparam int           STAT_STATE_LSB     = 0;
  localparam int           STAT_LANE_LSB      = 8;
  localparam int           STAT_ROLE_BIT      = 16;
  localparam int           STAT_SRC_LSB       = 17;
  localparam int           STAT_SLOT_LSB      = 20;

  // Reset values
  localparam logic [4:0]   RST_FIRST_IDX = 5'h00;
  localparam logic [4:0]   RST_LAST_IDX  = 5'h1F;

  typedef enum logic [1:0] {
    POL_DIRECT    = 2'b00,
    POL_INVERT    = 2'b01,
    POL_ALL_WHITE = 2'b10,
    POL_ALL_BLACK = 2'b11
  } adw_pol_t;

  typedef enum logic [1:0] {
    SRC_FLASH_FIXED = 2'b00,
    SRC_FLASH_TEMP  = 2'b01,
    SRC_CMD_SET     = 2'b10
  } adw_src_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_UPDATE = 2'b10
  } adw_st_t;

  // Software settings of the display
  typedef struct packed {
    adw_pol_t   polarity_mode_field;
    logic       auto_temperature_select;
    logic       flash_waveform_disable;
  } adw_ctrl_t;

  // Parameter window of the load-range command
  typedef struct packed {
    logic [4:0] first_param_index;
    logic [4:0] last_param_index;
  } adw_range_t;

  // Waveform choice handed to the update sequencer
  typedef struct packed {
    adw_src_t   src;
    logic [2:0] slot;
  } adw_wave_t;

endpackage : adw_pkg

// ==== rtl/adw_polarity.sv ====
`timescale 1ns/100ps
`default_nettype none
module adw_polarity
  import adw_pkg::*;
#(
  parameter int W = SEG_N
) (
  input  wire logic [W-1:0] image,
  input  wire adw_pol_t     mode,
  output logic [W-1:0]      black
);

  // Image bit to colour, 1 means black
  always_comb begin
    case (mode)
      POL_DIRECT:    black = image;
      POL_INVERT:    black = ~image;
      POL_ALL_WHITE: black = '0;
      POL_ALL_BLACK: black = '1;
      default:       black = image;
    endcase
  end

endmodule : adw_polarity
`default_nettype wire

// ==== rtl/adw_wave_sel.sv ====
`timescale 1ns/100ps
`default_nettype none
module adw_wave_sel
  import adw_pkg::*;
(
  input  wire logic       flash_waveform_disable,
  input  wire logic       role_slave,
  input  wire logic       auto_temperature_select,
  input  wire logic [2:0] temp_slot,
  output adw_wave_t       wave
);

  // Waveform memory priority: disable, then role, then temperature
  always_comb begin
    if (flash_waveform_disable) begin
      wave = '{src: SRC_CMD_SET, slot: WAVE_SLOT_NONE};
    end else if (role_slave) begin
      wave = '{src: SRC_FLASH_FIXED, slot: WAVE_SLOT_ONE};
    end else if (!auto_temperature_select) begin
      wave = '{src: SRC_FLASH_FIXED, slot: WAVE_SLOT_ONE};
    end else begin
      wave = '{src: SRC_FLASH_TEMP, slot: temp_slot};
    end
  end

endmodule : adw_wave_sel
`default_nettype wire

// ==== rtl/adw_loader.sv ====
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module adw_loader
  import adw_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              byte_valid,
  input  wire logic              byte_is_cmd,
  input  wire logic [BYTE_W-1:0] byte_data,
  input  wire logic              standby,
  input  wire logic              upd_done,
  input  wire logic              chip_role_pin,
  input  wire logic [2:0]        temp_slot,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   upd_start,
  output adw_wave_t              wave,
  output logic [SEG_N-1:0]       segment_output,
  output logic [SEG_N-1:0]       current_image
);

  typedef struct packed {
    adw_st_t          st;
    logic [LANE_W-1:0] lane;
    logic [SEG_N-1:0] next_segment_image;
    logic [SEG_N-1:0] cur_image;
    logic [SEG_N-1:0] seg_drive;
    adw_wave_t        wave;
    logic             upd_start;
    adw_ctrl_t        ctrl;
    adw_range_t       range;
    logic             role_meta;
    logic             role_sync;
    logic             ack;
    logic [31:0]      rdata;
  } adw_state_t;

  adw_state_t       r;
  adw_state_t       next_r;
  logic [SEG_N-1:0] mapped;
  adw_wave_t        wave_pick;
  logic             cmd_ours;
  logic             data_take;
  logic             wb_req;
  logic [2:0]       img_word;

  // Segment colour map from the held image
  adw_polarity #(
    .W (SEG_N)
  ) u_polarity (
    .image (r.next_segment_image),
    .mode  (r.ctrl.polarity_mode_field),
    .black (mapped)
  );

  // Waveform memory choice
  adw_wave_sel u_wave_sel (
    .flash_waveform_disable  (r.ctrl.flash_waveform_disable),
    .role_slave              (r.role_sync),
    .auto_temperature_select (r.ctrl.auto_temperature_select),
    .temp_slot               (temp_slot),
    .wave                    (wave_pick)
  );

  // Decoded command and bus strobes
  // code match
  assign cmd_ours  = byte_valid && byte_is_cmd && (byte_data[6:0] == CMD_AUTO_WRITE_ONE);
  assign data_take = byte_valid && !byte_is_cmd && (r.st == ST_LOAD);
  assign wb_req    = wb_cyc_i && wb_stb_i && !r.ack;
  assign img_word  = wb_adr_i[4:2];

  // Next state of the whole block
  always_comb begin
    next_r           = r;
    next_r.upd_start = 1'b0;
    next_r.ack       = wb_req;
    // Pin synchroniser
    next_r.role_meta = chip_role_pin;
    next_r.role_sync = r.role_meta;
    next_r.seg_drive = mapped;
    next_r.wave      = wave_pick;

    case (r.st)
      ST_IDLE: begin
        if (cmd_ours && standby) begin
          next_r.st   = ST_LOAD;
          next_r.lane = {1'b0, r.range.first_param_index};
        end
      end
      ST_LOAD: begin
        if (byte_valid && byte_is_cmd) begin
          // Any new command ends the load; ours restarts it while standby is high
          next_r.st   = (cmd_ours && standby) ? ST_LOAD : ST_IDLE;
          next_r.lane = {1'b0, r.range.first_param_index};
        end else if (data_take && (r.lane < LANE_LIMIT)) begin
          next_r.next_segment_image[{r.lane[4:0], 3'b000} +: BYTE_W] = byte_data;
          next_r.lane = r.lane + LANE_STEP;
          if (r.lane[4:0] == r.range.last_param_index) begin
            next_r.st        = ST_UPDATE;
            next_r.upd_start = 1'b1;
          end
        end
      end
      ST_UPDATE: begin
        if (upd_done) begin
          next_r.cur_image = r.next_segment_image;
          next_r.st        = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // Register reads
    next_r.rdata = '0;
    if (wb_req && !wb_we_i) begin
      if (wb_adr_i == ADDR_CTRL) begin
        next_r.rdata[CTRL_FLASH_DIS_BIT] = r.ctrl.flash_waveform_disable;
        next_r.rdata[CTRL_AUTO_TEMP_BIT] = r.ctrl.auto_temperature_select;
        next_r.rdata[CTRL_POL_LSB +: 2]  = r.ctrl.polarity_mode_field;
      end else if (wb_adr_i == ADDR_RANGE) begin
        next_r.rdata[RANGE_FIRST_LSB +: IDX_W] = r.range.first_param_index;
        next_r.rdata[RANGE_LAST_LSB +: IDX_W]  = r.range.last_param_index;
      end else if (wb_adr_i == ADDR_STATUS) begin
        next_r.rdata[STAT_STATE_LSB +: 2]     = r.st;
        next_r.rdata[STAT_LANE_LSB +: LANE_W] = r.lane;
        next_r.rdata[STAT_ROLE_BIT]           = r.role_sync;
        next_r.rdata[STAT_SRC_LSB +: 2]       = r.wave.src;
        next_r.rdata[STAT_SLOT_LSB +: 3]      = r.wave.slot;
      end else if ((wb_adr_i >= ADDR_IMAGE_BASE) && (wb_adr_i <= ADDR_IMAGE_LAST)
                   && (wb_adr_i[1:0] == 2'b00)) begin
        next_r.rdata = r.next_segment_image[{img_word, 5'b00000} +: 32];
      end
    end

    // Register writes, byte lanes honoured
    if (wb_req && wb_we_i) begin
      if ((wb_adr_i == ADDR_CTRL) && wb_sel_i[0]) begin
        next_r.ctrl.flash_waveform_disable  = wb_dat_i[CTRL_FLASH_DIS_BIT];
        next_r.ctrl.auto_temperature_select = wb_dat_i[CTRL_AUTO_TEMP_BIT];
        next_r.ctrl.polarity_mode_field     = adw_pol_t'(wb_dat_i[CTRL_POL_LSB +: 2]);
      end
      if ((wb_adr_i == ADDR_RANGE) && wb_sel_i[0]) begin
        next_r.range.first_param_index = wb_dat_i[RANGE_FIRST_LSB +: IDX_W];
      end
      if ((wb_adr_i == ADDR_RANGE) && wb_sel_i[1]) begin
        next_r.range.last_param_index = wb_dat_i[RANGE_LAST_LSB +: IDX_W];
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r                      <= '0;
      r.next_segment_image   <= '0;
      r.st                   <= ST_IDLE;
      r.range.first_param_index <= RST_FIRST_IDX;
      r.range.last_param_index  <= RST_LAST_IDX;
      r.wave                 <= '{src: SRC_FLASH_FIXED, slot: WAVE_SLOT_ONE};
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o       = r.rdata;
  assign wb_ack_o       = r.ack;
  assign upd_start      = r.upd_start;
  assign wave           = r.wave;
  assign segment_output = r.seg_drive;
  assign current_image  = r.cur_image;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_cmd_opens_load: assert property (
    ce && r.st == ST_IDLE && standby && byte_valid && byte_is_cmd
      && byte_data[6:0] == CMD_AUTO_WRITE_ONE |=> r.st == ST_LOAD)
    else $error("write command not taken");

  chk_first_lane_fill: assert property (
    ce && data_take && r.lane == '0 |=> r.next_segment_image[7:0] == $past(byte_data))
    else $error("first lane not filled");

  chk_segment_follows: assert property (
    ce && r.ctrl.polarity_mode_field == POL_DIRECT
      |=> segment_output == $past(r.next_segment_image))
    else $error("segment does not follow image");

  chk_last_byte_start: assert property (
    ce && data_take && r.lane < LANE_LIMIT
      && r.lane[4:0] == r.range.last_param_index |=> upd_start && r.st == ST_UPDATE)
    else $error("update not started on last byte");

  chk_flash_off_cmd: assert property (
    ce && r.ctrl.flash_waveform_disable |=> wave.src == SRC_CMD_SET)
    else $error("command waveform not chosen");

  chk_slave_slot_one: assert property (
    ce && !r.ctrl.flash_waveform_disable && r.role_sync
      |=> wave.src == SRC_FLASH_FIXED && wave.slot == WAVE_SLOT_ONE)
    else $error("slave chip not on slot one");

  chk_master_fixed: assert property (
    ce && !r.ctrl.flash_waveform_disable && !r.role_sync && !r.ctrl.auto_temperature_select
      |=> wave.slot == WAVE_SLOT_ONE)
    else $error("master fixed slot wrong");

  chk_temp_slot: assert property (
    ce && !r.ctrl.flash_waveform_disable && !r.role_sync && r.ctrl.auto_temperature_select
      |=> wave.src == SRC_FLASH_TEMP && wave.slot == $past(temp_slot))
    else $error("temperature slot not used");

  chk_standby_gate: assert property (
    r.st == ST_IDLE && !standby |=> r.st == ST_IDLE)
    else $error("command taken outside standby");

  chk_white_forced: assert property (
    ce && r.ctrl.polarity_mode_field == POL_ALL_WHITE |=> segment_output == '0)
    else $error("segments not all white");

  chk_black_forced: assert property (
    ce && r.ctrl.polarity_mode_field == POL_ALL_BLACK |=> segment_output == '1)
    else $error("segments not all black");

  chk_store_current: assert property (
    ce && r.st == ST_UPDATE && upd_done |=> current_image == $past(r.next_segment_image)
      && r.st == ST_IDLE)
    else $error("displayed data not kept");

  chk_surplus_ignored: assert property (
    ce && r.st == ST_LOAD && r.lane >= LANE_LIMIT && !byte_is_cmd
      |=> $stable(r.next_segment_image))
    else $error("byte past lane 32 written");

endmodule : adw_loader
`default_nettype wire

// ==== tb/adw_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module adw_host_model
  import adw_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         upd_start,
  output logic              byte_valid,
  output logic              byte_is_cmd,
  output logic [BYTE_W-1:0] byte_data,
  output logic              standby,
  output logic              upd_done
);
  logic busy;
  logic hold_off;
  int   delay;
  int   cnt;
  int   starts;

  // Quiet link and idle sequencer at time zero
  initial begin
    byte_valid = 1'b0;
    byte_is_cmd = 1'b0;
    byte_data = 8'h00;
    upd_done = 1'b0;
    busy = 1'b0;
    hold_off = 1'b0;
    delay = 2;
    cnt = 0;
    starts = 0;
  end

  assign standby = !busy && !hold_off;

  // Sequencer finishes an update after a settable delay
  always @(posedge ref_clk) begin
    upd_done <= 1'b0;
    if (upd_start === 1'b1) begin
      busy <= 1'b1;
      cnt <= delay;
      starts <= starts + 1;
    end else if (busy && cnt == 0) begin
      busy <= 1'b0;
      upd_done <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end

  // one byte per call, released data shows the inverse
  task automatic send(input logic c, input logic [7:0] d);
    @(posedge ref_clk);
    byte_valid <= 1'b1;
    byte_is_cmd <= c;
    byte_data <= d;
    @(posedge ref_clk);
    byte_valid <= 1'b0;
    byte_data <= ~d;
  endtask : send
endmodule : adw_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
  import adw_pkg::*;
;
  logic         ref_clk, rst_n, ce, byte_valid, byte_is_cmd, standby, upd_done;
  logic         chip_role_pin, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, upd_start;
  logic [7:0]   byte_data, wb_adr_i;
  logic [2:0]   temp_slot;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  adw_wave_t    wave, ew;
  logic [255:0] segment_output, current_image, exp_img, e, v;
  int           fails, samples_checked, cycles;

  adw_loader adw_loader_inst (.ref_clk, .rst_n, .ce, .byte_valid, .byte_is_cmd,
    .byte_data, .standby, .upd_done, .chip_role_pin, .temp_slot, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .upd_start, .wave, .segment_output, .current_image);

  adw_host_model adw_host_model_inst (.ref_clk, .upd_start, .byte_valid,
    .byte_is_cmd, .byte_data, .standby, .upd_done);

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic [255:0] x, input logic [255:0] g);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // Classic single Wishbone cycle
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic rd_img(output logic [255:0] r);
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      wb_xfer(ADDR_IMAGE_BASE + 8'(4 * i), 1'b0, 32'h0, d);
      r[32*i +: 32] = d;
    end
  endtask : rd_img

  // Range, opcode, bytes, one stray byte, then wait out the update
  task automatic load(input int f, input int l, input logic [7:0] op, input logic acc);
    int          s;
    logic [7:0]  b;
    logic [31:0] d;
    logic [255:0] r;
    s = adw_host_model_inst.starts;
    wb_xfer(ADDR_RANGE, 1'b1, (32'(l) << RANGE_LAST_LSB) | 32'(f), d);
    adw_host_model_inst.send(1'b1, op);
    for (int k = f; k <= l; k++) begin
      b = 8'(k * 37 + 11);
      adw_host_model_inst.send(1'b0, b);
      if (acc) exp_img[8*k +: 8] = b;
    end
    adw_host_model_inst.send(1'b0, 8'h5A);
    repeat (3) @(posedge ref_clk);
    while (adw_host_model_inst.busy) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    chk("starts", 256'(s + 32'(acc)), 256'(adw_host_model_inst.starts));
    rd_img(r);
    chk("image", exp_img, r);
    if (acc) chk("current", exp_img, current_image);
    $display("test load %0d to %0d op %h done", f, l, op);
  endtask : load

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    chip_role_pin = 1'b0;
    temp_slot = 3'h5;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    exp_img = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_img(v);
    chk("image", exp_img, v);
    chk("wave", 256'({SRC_FLASH_FIXED, WAVE_SLOT_ONE}), 256'(wave));
    wb_xfer(8'hF0, 1'b0, 32'h0, q);
    chk("unmapped", '0, 256'(q));
    $display("test reset done");
    load(0, 31, 8'h83, 1'b1);
    adw_host_model_inst.delay = 30;
    load(4, 6, 8'h03, 1'b1);
    adw_host_model_inst.hold_off = 1'b1;
    load(8, 9, 8'h03, 1'b0);
    adw_host_model_inst.hold_off = 1'b0;
    load(10, 11, 8'h04, 1'b0);
    // Window past the last lane: bytes at lane 32 and beyond are dropped
    wb_xfer(ADDR_RANGE, 1'b1, (32'(1) << RANGE_LAST_LSB) | 32'(30), q);
    adw_host_model_inst.send(1'b1, 8'h03);
    for (int k = 30; k < 33; k++) begin
      adw_host_model_inst.send(1'b0, 8'(k));
      if (k < 32) exp_img[8*k +: 8] = 8'(k);
    end
    wb_xfer(ADDR_STATUS, 1'b0, 32'h0, q);
    chk("state", 256'(ST_LOAD), 256'(q[STAT_STATE_LSB +: 2]));
    chk("lane", 256'(LANE_LIMIT), 256'(q[STAT_LANE_LSB +: LANE_W]));
    adw_host_model_inst.send(1'b1, 8'h00);
    rd_img(v);
    chk("image", exp_img, v);
    // Clock enable low: an opcode in standby is not taken
    ce <= 1'b0;
    adw_host_model_inst.send(1'b1, 8'h03);
    ce <= 1'b1;
    wb_xfer(ADDR_STATUS, 1'b0, 32'h0, q);
    chk("state", 256'(ST_IDLE), 256'(q[STAT_STATE_LSB +: 2]));
    $display("test surplus done");
    for (int m = 0; m < 4; m++) begin
      wb_xfer(ADDR_CTRL, 1'b1, 32'(m) << CTRL_POL_LSB, q);
      repeat (3) @(posedge ref_clk);
      e = (m == 0) ? exp_img : (m == 1) ? ~exp_img : (m == 2) ? '0 : '1;
      chk("segments", e, segment_output);
    end
    $display("test polarity done");
    for (int i = 0; i < 8; i++) begin
      wb_xfer(ADDR_CTRL, 1'b1, 32'(i[1:0]), q);
      chip_role_pin <= i[2];
      repeat (6) @(posedge ref_clk);
      ew = i[0] ? {SRC_CMD_SET, WAVE_SLOT_NONE} :
           (i[2] || !i[1]) ? {SRC_FLASH_FIXED, WAVE_SLOT_ONE} : {SRC_FLASH_TEMP, temp_slot};
      chk("wave", 256'(ew), 256'(wave));
    end
    $display("test waveform done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
